// *** trig_seq_defs.svh ***
// constants for the trigger sequencer: offsets, field positions, reset values, timing
`ifndef TRIG_SEQ_DEFS_SVH
`define TRIG_SEQ_DEFS_SVH
`define CLK_FREQ_HZ        200000000
`define TICK_PERIOD_MS     1
`define TICK_CYCLES        (`CLK_FREQ_HZ / 1000 * `TICK_PERIOD_MS)
`define MS_W               14
`define TIMEOUT_MIN_MS     14'h000A
`define TIMEOUT_MAX_MS     14'h270F
`define TIMEOUT_RST_MS     14'h270F
`define DELAY_MAX_MS       14'h270F
`define DELAY_RST_MS       14'h0000
// register byte offsets
`define REG_CTRL           4'h0
`define REG_START_DLY      4'h4
`define REG_END_DLY        4'h8
`define REG_TIMEOUT        4'hC
// control register fields
`define CTRL_ENABLE        0
`define CTRL_CONT          1
`define CTRL_SINGLE_EXT    2
`define CTRL_START_SRC     3
`define CTRL_START_FALL    4
`define CTRL_END_SRC       5
`define CTRL_END_FALL      6
`define CTRL_READING       8
`define CTRL_STATE_LSB     9
`define CTRL_RST           7'h04
`endif

// *** trig_seq_pkg.sv ***
// types shared by the trigger sequencer files
package trig_seq_pkg;
   // sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0001,
      ST_START_WT = 4'b0010,
      ST_READING  = 4'b0100,
      ST_END_WT   = 4'b1000
   } seq_state_e;
   // software configuration
   typedef struct packed {
      logic        enable;
      logic        cont;
      logic        single_ext;
      logic        start_src;   // 0 trigger_source_first, 1 trigger_source_second
      logic        start_fall;
      logic        end_src;
      logic        end_fall;
      logic [13:0] start_dly;
      logic [13:0] end_dly;
      logic [13:0] timeout;
   } cfg_s;
   // trigger input synchroniser and edge state
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] sync;
      logic [1:0] prev;
   } sync_s;
endpackage

// *** trig_edge_sync.sv ***
// two-flop synchroniser and rise/fall detector for the two trigger inputs
`timescale 1ns/10ps
module trig_edge_sync
   import trig_seq_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // raw pins
   input  wire logic [1:0] pin_i,
   // one-cycle edge pulses
   output logic      [1:0] rise_o,
   output logic      [1:0] fall_o
);
   sync_s r;        // registered state
   sync_s next_r;   // next state

   // meta is only read by sync, edges compare sync with prev
   always_comb begin
      next_r      = r;
      next_r.meta = pin_i;
      next_r.sync = r.meta;
      next_r.prev = r.sync;
   end

   // register the state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // successive sampled values give the edges
   assign rise_o = r.sync & ~r.prev;
   assign fall_o = ~r.sync & r.prev;
endmodule // trig_edge_sync

// *** io_trigger_sequencer.sv ***
// io trigger sequencer: start/end events, delays, task timeout, continuous mode, wishbone slave
// Notes on behaviour
// - continuous mode fires captures back to back
// - io trigger acts only in single external mode
// - timeout 10..9999 ms forces an io-mode session closed; continuous reading is never timed out
// - wait start delay after start event
// - keep reading end delay after end event
// - start event input selectable a or b
// - end event input independently selectable
// - start polarity rising or falling selectable
// - end polarity rising or falling selectable
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`include "trig_seq_defs.svh"
module io_trigger_sequencer
   import trig_seq_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES   // clock cycles per millisecond
)(
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_I,
   // wishbone slave
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [3:0]  ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   // hardware trigger pins
   input  wire logic        HW_TRIGGER_INPUT_A_I,
   input  wire logic        HW_TRIGGER_INPUT_B_I,
   // session outputs
   output logic             READING_O,
   output logic             CAPTURE_O,
   output logic             TIMEOUT_O
);
   // all module state
   typedef struct packed {
      cfg_s        cfg;
      seq_state_e  st;
      logic [31:0] tick_cnt;
      logic        tick;
      logic [13:0] dly_cnt;     // delay in progress, ms
      logic [13:0] to_cnt;      // session age, ms
      logic        reading;
      logic        capture;
      logic        timeout;
      logic        ack;
      logic [31:0] dat;
   } state_s;

   state_s r;          // registered state
   state_s next_r;     // next state
   logic [1:0] rise;   // synchronised edges
   logic [1:0] fall;
   logic start_ev;     // selected start event
   logic end_ev;       // selected end event
   logic io_mode;      // io trigger active
   logic wb_req;       // new bus request
   logic [13:0] wr14;  // write data low bits
   logic [13:0] to_wr; // clamped timeout

   // input synchroniser and edge detector
   trig_edge_sync u_sync (
      .clk_i  (CLK_SYS_I),
      .rst_i  (RST_I),
      .pin_i  ({HW_TRIGGER_INPUT_B_I, HW_TRIGGER_INPUT_A_I}),
      .rise_o (rise),
      .fall_o (fall)
   );

   // event selection; index 0 is input a, 1 is input b
   assign start_ev = r.cfg.start_fall ? fall[r.cfg.start_src] : rise[r.cfg.start_src];
   assign end_ev   = r.cfg.end_fall ? fall[r.cfg.end_src] : rise[r.cfg.end_src];
   assign io_mode  = r.cfg.enable & r.cfg.single_ext & ~r.cfg.cont;
   assign wb_req   = CYC_I & STB_I & ~r.ack;
   assign wr14     = DAT_I[13:0];

   // clamp the timeout into its legal range
   always_comb begin
      to_wr = wr14;
      if (wr14 < `TIMEOUT_MIN_MS) begin
         to_wr = `TIMEOUT_MIN_MS;
      end else if (wr14 > `TIMEOUT_MAX_MS) begin
         to_wr = `TIMEOUT_MAX_MS;
      end
   end

   // next-state logic: tick, sequencer, bus
   always_comb begin
      next_r         = r;
      next_r.capture = 1'b0;
      next_r.timeout = 1'b0;
      next_r.ack     = 1'b0;
      // millisecond tick divider
      next_r.tick = 1'b0;
      if (r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
         next_r.tick_cnt = '0;
         next_r.tick     = 1'b1;
      end else begin
         next_r.tick_cnt = r.tick_cnt + 32'h1;
      end
      // sequencer
      case (r.st)
         ST_IDLE: begin
            next_r.reading = 1'b0;
            next_r.to_cnt  = '0;
            if (r.cfg.enable && r.cfg.cont) begin
               // free-running: one capture per cycle, no external event
               next_r.capture = 1'b1;
               next_r.reading = 1'b1;
            end else if (io_mode && start_ev) begin
               next_r.dly_cnt = r.cfg.start_dly;
               if (r.cfg.start_dly == '0) begin
                  next_r.st      = ST_READING;
                  next_r.reading = 1'b1;
                  next_r.capture = 1'b1;
               end else begin
                  next_r.st = ST_START_WT;
               end
            end
         end
         ST_START_WT: begin
            // start events here are ignored; session already begun
            if (r.tick) begin
               next_r.to_cnt = r.to_cnt + 14'h1;
               if (r.dly_cnt == 14'h1) begin
                  next_r.st      = ST_READING;
                  next_r.reading = 1'b1;
                  next_r.capture = 1'b1;
               end
               next_r.dly_cnt = r.dly_cnt - 14'h1;
            end
         end
         ST_READING: begin
            if (r.tick) begin
               next_r.to_cnt = r.to_cnt + 14'h1;
            end
            if (end_ev) begin
               next_r.dly_cnt = r.cfg.end_dly;
               if (r.cfg.end_dly == '0) begin
                  next_r.st      = ST_IDLE;
                  next_r.reading = 1'b0;
               end else begin
                  next_r.st = ST_END_WT;
               end
            end
         end
         ST_END_WT: begin
            // still reading until the end delay runs out
            if (r.tick) begin
               next_r.to_cnt = r.to_cnt + 14'h1;
               if (r.dly_cnt == 14'h1) begin
                  next_r.st      = ST_IDLE;
                  next_r.reading = 1'b0;
               end
               next_r.dly_cnt = r.dly_cnt - 14'h1;
            end
         end
         default: begin
            next_r.st      = ST_IDLE;
            next_r.reading = 1'b0;
         end
      endcase
      // task timeout closes any open io-mode session, not continuous reading (which stays in ST_IDLE); start events never restart it
      if (r.st != ST_IDLE && r.tick && (r.to_cnt + 14'h1) >= r.cfg.timeout) begin
         next_r.st      = ST_IDLE;
         next_r.reading = 1'b0;
         next_r.capture = 1'b0;      // a start delay ending on the same tick must not fire a lone capture
         next_r.timeout = 1'b1;
      end
      // leaving io mode abandons the session
      if (r.st != ST_IDLE && !io_mode) begin
         next_r.st      = ST_IDLE;
         next_r.reading = 1'b0;
         next_r.capture = 1'b0;      // no capture from an abandoned session
      end
      // wishbone slave, one wait state, ack drops after one cycle
      if (wb_req) begin
         next_r.ack = 1'b1;
         next_r.dat = '0;
         case (ADR_I)
            `REG_CTRL: begin
               next_r.dat[6:0] = {r.cfg.end_fall, r.cfg.end_src, r.cfg.start_fall, r.cfg.start_src,
                                  r.cfg.single_ext, r.cfg.cont, r.cfg.enable};
               next_r.dat[`CTRL_READING] = r.reading;
               next_r.dat[`CTRL_STATE_LSB +: 4] = r.st;
               if (WE_I && SEL_I[0]) begin
                  next_r.cfg.enable     = DAT_I[`CTRL_ENABLE];
                  next_r.cfg.cont       = DAT_I[`CTRL_CONT];
                  next_r.cfg.single_ext = DAT_I[`CTRL_SINGLE_EXT];
                  next_r.cfg.start_src  = DAT_I[`CTRL_START_SRC];
                  next_r.cfg.start_fall = DAT_I[`CTRL_START_FALL];
                  next_r.cfg.end_src    = DAT_I[`CTRL_END_SRC];
                  next_r.cfg.end_fall   = DAT_I[`CTRL_END_FALL];
               end
            end
            `REG_START_DLY: begin
               next_r.dat[13:0] = r.cfg.start_dly;
               if (WE_I && SEL_I[1:0] == 2'h3) begin
                  next_r.cfg.start_dly = (wr14 > `DELAY_MAX_MS) ? `DELAY_MAX_MS : wr14;
               end
            end
            `REG_END_DLY: begin
               next_r.dat[13:0] = r.cfg.end_dly;
               if (WE_I && SEL_I[1:0] == 2'h3) begin
                  next_r.cfg.end_dly = (wr14 > `DELAY_MAX_MS) ? `DELAY_MAX_MS : wr14;
               end
            end
            `REG_TIMEOUT: begin
               next_r.dat[13:0] = r.cfg.timeout;
               if (WE_I && SEL_I[1:0] == 2'h3) begin
                  next_r.cfg.timeout = to_wr;
               end
            end
            default: begin
               next_r.dat = '0;   // unmapped reads zero, writes ignored
            end
         endcase
      end
   end

   // register the state
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         r                    <= '0;
         r.st                 <= ST_IDLE;
         r.cfg.single_ext     <= 1'b1;
         r.cfg.start_dly      <= `DELAY_RST_MS;
         r.cfg.end_dly        <= `DELAY_RST_MS;
         r.cfg.timeout        <= `TIMEOUT_RST_MS;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flops
   assign DAT_O     = r.dat;
   assign ACK_O     = r.ack;
   assign READING_O = r.reading;
   assign CAPTURE_O = r.capture;
   assign TIMEOUT_O = r.timeout;
endmodule // io_trigger_sequencer

// *** io_trigger_sequencer_properties.sv ***
// port checker for the trigger sequencer, bound to the top module
`timescale 1ns/10ps
module io_trigger_sequencer_properties (
   // clock and reset
   input  wire logic CLK_SYS_I,
   input  wire logic RST_I,
   // bus handshake
   input  wire logic CYC_I,
   input  wire logic STB_I,
   input  wire logic ACK_O,
   // session outputs
   input  wire logic READING_O,
   input  wire logic CAPTURE_O,
   input  wire logic TIMEOUT_O
);
   // one clock domain, so one default for all
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   // a taken request is answered after exactly one wait state
   ack_wait_state_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack not one cycle late");
   ack_one_cycle_a: assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
   ack_needs_req_a: assert property (!(CYC_I && STB_I) |=> !ACK_O) else $error("ack without request");
   ack_with_req_a: assert property (ACK_O |-> CYC_I && STB_I) else $error("ack outside a cycle");
   // reset must leave every session output quiet, so it is not disabled by itself
   reset_quiet_a: assert property (disable iff (1'b0) RST_I |=> !READING_O && !CAPTURE_O && !TIMEOUT_O)
      else $error("outputs busy after reset");
   capture_at_start_a: assert property ($rose(READING_O) |-> CAPTURE_O) else $error("no capture at start");
   capture_in_read_a: assert property (CAPTURE_O |-> READING_O) else $error("capture while idle");
   timeout_pulse_a: assert property (TIMEOUT_O |=> !TIMEOUT_O) else $error("timeout not a pulse");
   timeout_closes_a: assert property (TIMEOUT_O |=> !READING_O) else $error("timeout left session open");
   // main scenarios reached
   cover property ($rose(READING_O));
   cover property (TIMEOUT_O);
   cover property (CAPTURE_O [*3]);
endmodule // io_trigger_sequencer_properties

bind io_trigger_sequencer io_trigger_sequencer_properties i_props (.CLK_SYS_I, .RST_I, .CYC_I, .STB_I,
   .ACK_O, .READING_O, .CAPTURE_O, .TIMEOUT_O);

// *** trig_partner.sv ***
// model of the external switch that drives both trigger pins
`timescale 1ns/10ps
module trig_partner (
   // pacing clock
   input  wire logic clk_i,
   // pins toward the reader
   output logic      pin_a_o,
   output logic      pin_b_o
);
   // both pins start low, a released switch
   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
   end
   // one clean level change just after an edge; a real switch is not synchronous, the reader must cope
   task automatic drive(input logic sel, input logic lvl);
      @(posedge clk_i);
      if (sel) pin_b_o <= lvl;
      else pin_a_o <= lvl;
   endtask
endmodule // trig_partner

// *** io_trigger_sequencer_test.sv ***
// self-checking bench for the trigger sequencer
`timescale 1ns/10ps
`include "trig_seq_defs.svh"
module io_trigger_sequencer_test;
   localparam int TK = 20; // short millisecond keeps the run brief
   logic        clk, rst, cyc, stb, we, ack, reading, capture, tmo, pin_a, pin_b;
   logic [3:0]  adr, sel;
   logic [31:0] dat_w, dat_r, rd;
   int          err_count = 0;
   int          checks = 0;
   int          caps = 0;      // capture pulses counted over the whole run, continuous mode included; only t_edges reads the count
   io_trigger_sequencer #(.TICK_CYCLES(TK)) i_dut (.CLK_SYS_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
      .HW_TRIGGER_INPUT_A_I(pin_a), .HW_TRIGGER_INPUT_B_I(pin_b), .READING_O(reading), .CAPTURE_O(capture),
      .TIMEOUT_O(tmo));
   trig_partner i_partner (.clk_i(clk), .pin_a_o(pin_a), .pin_b_o(pin_b));
   // count capture pulses as they stand at each edge
   always @(posedge clk) begin
      if (capture === 1'b1) begin
         caps <= caps + 1;
      end
   end
   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // classic cycle: request held until ack is sampled high
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hF, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n == 20) err_count++;
      rd = dat_r;
      {cyc, stb} <= 2'b00;
   endtask
   // all four registers, control last so the new mode starts cleanly
   task automatic cfg(input logic [31:0] c, s, e, t);
      bus(1'b1, `REG_START_DLY, s);
      bus(1'b1, `REG_END_DLY, e);
      bus(1'b1, `REG_TIMEOUT, t);
      bus(1'b1, `REG_CTRL, c);
   endtask
   // wait a bounded time for the reading level
   task automatic wait_rd(input logic lvl, input int n, input string msg);
      repeat (n) begin
         @(posedge clk);
         if (reading === lvl) break;
      end
      check(reading, lvl, msg);
   endtask
   // reading must hold its level for n cycles
   task automatic stay(input logic lvl, input int n, input string msg);
      logic bad = 1'b0;
      repeat (n) begin
         @(posedge clk);
         if (reading !== lvl) bad = 1'b1;
      end
      check(bad, 1'b0, msg);
   endtask
   // reset values, unmapped place, clamping
   task automatic t_regs();
      bus(1'b0, `REG_CTRL, 32'h0);
      check(rd, `CTRL_RST | (32'h1 << `CTRL_STATE_LSB), "ctrl reset");
      bus(1'b0, `REG_TIMEOUT, 32'h0);
      check(rd, `TIMEOUT_RST_MS, "timeout reset");
      bus(1'b0, `REG_START_DLY, 32'h0);
      check(rd, `DELAY_RST_MS, "delay reset");
      bus(1'b0, 4'h2, 32'h0);
      check(rd, 32'h0, "unmapped read");
      bus(1'b1, `REG_TIMEOUT, 32'h5);
      bus(1'b0, `REG_TIMEOUT, 32'h0);
      check(rd, `TIMEOUT_MIN_MS, "timeout low clamp");
      bus(1'b1, `REG_END_DLY, 32'hFFFF);
      bus(1'b0, `REG_END_DLY, 32'h0);
      check(rd, `DELAY_MAX_MS, "delay clamp");
   endtask
   // start on a rising, end on b falling, extra starts ignored
   task automatic t_edges();
      int c0;
      cfg(32'h65, 32'h0, 32'h0, `TIMEOUT_MAX_MS);
      c0 = caps;
      i_partner.drive(1'b0, 1'b1);
      wait_rd(1'b1, 8, "no start on a rise");
      i_partner.drive(1'b0, 1'b0);
      i_partner.drive(1'b0, 1'b1);
      i_partner.drive(1'b1, 1'b1);
      stay(1'b1, 10, "wrong edge ended session");
      check(caps - c0, 32'h1, "capture count at start");
      i_partner.drive(1'b1, 1'b0);
      wait_rd(1'b0, 8, "no end on b fall");
      i_partner.drive(1'b0, 1'b0);
   endtask
   // start on b falling after 2 ms, end on a rising after 2 ms
   task automatic t_delays();
      cfg(32'h1D, 32'h2, 32'h2, `TIMEOUT_MAX_MS);
      i_partner.drive(1'b1, 1'b1);
      stay(1'b0, 10, "rise started falling mode");
      i_partner.drive(1'b1, 1'b0);
      stay(1'b0, TK, "start delay too short");
      wait_rd(1'b1, 2 * TK + 8, "start delay too long");
      i_partner.drive(1'b0, 1'b1);
      stay(1'b1, TK, "end delay too short");
      wait_rd(1'b0, 2 * TK + 8, "end delay too long");
      i_partner.drive(1'b0, 1'b0);
   endtask
   // shortest timeout closes a session with no end event
   task automatic t_timeout();
      int n = 0;
      cfg(32'h05, 32'h0, 32'h0, `TIMEOUT_MIN_MS);
      i_partner.drive(1'b0, 1'b1);
      wait_rd(1'b1, 8, "no start");
      stay(1'b1, 8 * TK, "timeout too early");
      while (tmo !== 1'b1 && n < 4 * TK) begin
         @(posedge clk);
         n++;
      end
      check(tmo, 1'b1, "no timeout");
      wait_rd(1'b0, 2, "session still open");
      i_partner.drive(1'b0, 1'b0);
   endtask
   // io trigger needs single external mode; continuous fires every cycle
   task automatic t_modes();
      int n = 0;
      cfg(32'h01, 32'h0, 32'h0, `TIMEOUT_MAX_MS);
      i_partner.drive(1'b0, 1'b1);
      stay(1'b0, 15, "started outside single mode");
      i_partner.drive(1'b0, 1'b0);
      bus(1'b1, `REG_CTRL, 32'h03);
      wait_rd(1'b1, 8, "continuous not reading");
      repeat (4) begin
         @(posedge clk);
         n += capture;
      end
      check(n, 4, "captures not back to back");
      bus(1'b1, `REG_CTRL, 32'h0);
      wait_rd(1'b0, 8, "continuous did not stop");
   endtask
   // verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {rst, cyc, stb, we, adr, sel, dat_w} = {1'b1, 43'h0};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_edges();
      t_delays();
      t_timeout();
      t_modes();
      complete_run();
   end
   // watchdog, far beyond the few hundred cycles the tests take
   initial begin
      #60us;
      err_count++;
      complete_run();
   end
endmodule // io_trigger_sequencer_test
